/* File: analog_monitor.sv */
// supervisory front end: reset sequencing, adc scan, strap address, under-voltage action
// Operation
// R1: scan eight channels in fixed pin order
// R2: codes scale to 2.45V, 2.39mV steps
// R3: address is upper index times 12 plus lower
// R4: straps quantised into twelve 0.185V bands
// R5: strap above 2.22V gives address 127
// R6: both straps grounded give address 127
// R7: address latched at reset release, held; code latches it at the end of the first full scan after release
// R8: startup delay after supply good, then run
// R9: external reset high holds device in reset
// R10: output under-voltage turns output off, alarms
// R11: die temperature on its own adc channel
// R12: supply status readable at any time
// R13: band index from code thresholds, clamp above
// R14: per-channel results updated once per scan
`timescale 1ns/1ps
module analog_monitor
   import analog_monitor_pkg::*;
#(
   parameter int STARTUP_CNT = STARTUP_CYCLES,
   parameter logic [ADC_BITS-1:0] UV_THRESH = UV_THRESH_DEFAULT
)
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic bias_supply_ok,
   input wire logic ext_reset,
   output logic sys_reset_active,
   output logic adc_start,
   output logic [CH_W-1:0] adc_channel,
   input wire logic adc_done,
   input wire logic [ADC_BITS-1:0] adc_code,
   output logic [ADDR_W-1:0] bus_addr,
   output logic addr_valid,
   output logic output_off,
   output logic uv_alarm,
   output logic [STAT_W-1:0] supply_status,
   input wire logic [CH_W-1:0] rd_channel,
   output logic [ADC_BITS-1:0] rd_data
);

   // the startup counter is only as wide as the delay it has to count
   localparam int DELAY_W = $clog2(STARTUP_CNT + 1);

   if (STARTUP_CNT < 1) begin : g_bad_startup
      $error("startup count must be at least one cycle");
   end
   if (NUM_BANDS > (1 << BAND_W) - 1) begin : g_bad_bands
      $error("band count does not fit the band index field");
   end
   if (NUM_BANDS * BAND_UV != TOP_LIMIT_UV) begin : g_bad_limit
      $error("top strap limit is not the end of the last band");
   end
   if (NUM_CH > (1 << CH_W)) begin : g_bad_channels
      $error("channel count does not fit the channel field");
   end
   if (CH_LAST != CH_W'(NUM_CH - 1)) begin : g_bad_last
      $error("scan does not close on the last channel");
   end
   if (UV_THRESH == CODE_ZERO) begin : g_bad_thresh
      $error("a zero under-voltage level could never trip");
   end
   if (STAT_W <= STAT_OUT_OFF) begin : g_bad_status
      $error("status word too narrow for its flags");
   end
   if (uv_to_code(TOP_LIMIT_UV) > uv_to_code(FULL_SCALE_UV)) begin : g_bad_scale
      $error("top strap limit lies beyond adc full scale");
   end

   typedef struct packed {
      mon_state_e state;
      logic [DELAY_W-1:0] delay_cnt;
      logic [CH_W-1:0] ch;
      logic adc_start;
      logic [NUM_CH-1:0][ADC_BITS-1:0] shadow;
      logic [NUM_CH-1:0][ADC_BITS-1:0] result;
      logic [ADDR_W-1:0] bus_addr;
      logic addr_valid;
      logic scan_valid;
      logic uv_alarm;
      logic output_off;
      logic [ADC_BITS-1:0] rd_data;
   } mon_s;

   mon_s st_reg;
   mon_s st_next;

   logic [ADDR_W-1:0] decoded_addr;

   // the trip test feeds both the alarm and the sticky turn-off
   function automatic logic is_under(input logic [ADC_BITS-1:0] code);
      return code < UV_THRESH;
   endfunction

   // the die temperature slot follows the eight pins, then the scan wraps
   function automatic logic [CH_W-1:0] next_channel(input logic [CH_W-1:0] ch);
      logic [CH_W-1:0] nxt;
      nxt = ch + CH_W'(1);
      if (ch == CH_LAST) begin
         nxt = CH_STRAP_UPPER;
      end
      return nxt;
   endfunction

   // selects past the last channel read zero instead of aliasing a result
   function automatic logic [ADC_BITS-1:0] read_result(
      input logic [NUM_CH-1:0][ADC_BITS-1:0] res,
      input logic [CH_W-1:0] sel
   );
      logic [ADC_BITS-1:0] val;
      val = CODE_ZERO;
      if (sel <= CH_LAST) begin
         val = res[sel];
      end
      return val;
   endfunction

   function automatic logic [STAT_W-1:0] pack_status(input mon_s s, input logic ready);
      logic [STAT_W-1:0] w;
      w = '0;
      w[STAT_READY] = ready;
      w[STAT_UV] = s.uv_alarm;
      w[STAT_SCAN_VALID] = s.scan_valid;
      w[STAT_ADDR_VALID] = s.addr_valid;
      w[STAT_OUT_OFF] = s.output_off;
      return w;
   endfunction

   // strap codes come from the scan in progress, so the first full scan
   // after reset already carries both straps when the address is latched
   strap_decoder u_strap (
      .upper_code(st_reg.shadow[CH_STRAP_UPPER]),
      .lower_code(st_reg.shadow[CH_STRAP_LOWER]),
      .bus_addr(decoded_addr)
   );

   always_comb begin
      st_next = st_reg;
      st_next.adc_start = 1'b0;

      case (st_reg.state)
         ST_POR_WAIT: begin
            st_next.delay_cnt = '0;
            if (bias_supply_ok) begin
               st_next.state = ST_STARTUP; // R8
            end
         end
         ST_STARTUP: begin
            if (st_reg.delay_cnt >= DELAY_W'(STARTUP_CNT - 1)) begin
               st_next.state = ST_ISSUE; // R8
               st_next.ch = CH_STRAP_UPPER;
            end else begin
               st_next.delay_cnt = st_reg.delay_cnt + DELAY_W'(1);
            end
         end
         ST_ISSUE: begin
            st_next.adc_start = 1'b1;
            st_next.state = ST_CONVERT;
         end
         ST_CONVERT: begin
            // a done in the start cycle belongs to no conversion of ours
            if (adc_done && !st_reg.adc_start) begin
               st_next.shadow[st_reg.ch] = adc_code;
               st_next.state = ST_ISSUE;
               st_next.ch = next_channel(st_reg.ch); // R1 R11
               if (st_reg.ch == CH_LAST) begin
                  st_next.result = st_next.shadow; // R14
                  st_next.scan_valid = 1'b1;
                  if (!st_reg.addr_valid) begin
                     st_next.bus_addr = decoded_addr; // R7
                     st_next.addr_valid = 1'b1; // R7
                  end
               end
            end
         end
         default: begin
            st_next.state = ST_POR_WAIT;
         end
      endcase

      // under-voltage only judged on a completed scan; turn-off holds until reset
      if (st_reg.scan_valid) begin
         st_next.uv_alarm = is_under(st_reg.result[CH_OUTPUT_VOLT]); // R10 R2
         if (is_under(st_reg.result[CH_OUTPUT_VOLT])) begin
            st_next.output_off = 1'b1; // R10
         end
      end

      // results readable in any scan state; unknown channels read zero
      st_next.rd_data = read_result(st_reg.result, rd_channel); // R12

      // supply loss or the external pin drop everything back to reset;
      // clearing addr_valid forces a fresh strap sample on the next release
      if (ext_reset || !bias_supply_ok) begin
         st_next = '0; // R9 R8
         st_next.state = ST_POR_WAIT;
         st_next.bus_addr = ADDR_RESET;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   always_comb begin
      sys_reset_active = st_reg.state == ST_POR_WAIT || st_reg.state == ST_STARTUP; // R8 R9
      adc_start = st_reg.adc_start;
      adc_channel = st_reg.ch;
      bus_addr = st_reg.bus_addr;
      addr_valid = st_reg.addr_valid;
      output_off = st_reg.output_off;
      uv_alarm = st_reg.uv_alarm;
      rd_data = st_reg.rd_data;
      // ready is handed over so the status bit and the reset output agree
      supply_status = pack_status(st_reg, !sys_reset_active); // R12
   end

endmodule

/* File: analog_monitor_pkg.sv */
// constants and types shared by the analog monitor and the strap decoder
package analog_monitor_pkg;

   // adc and scan layout
   localparam int ADC_BITS = 10;
   localparam int NUM_EXT_CH = 8;
   localparam int NUM_CH = NUM_EXT_CH + 1;
   localparam int CH_W = 4;
   localparam logic [CH_W-1:0] CH_STRAP_UPPER = 4'h0;
   localparam logic [CH_W-1:0] CH_STRAP_LOWER = 4'h1;
   localparam logic [CH_W-1:0] CH_PHASE_ONE = 4'h2;
   localparam logic [CH_W-1:0] CH_INPUT_VOLT = 4'h3;
   localparam logic [CH_W-1:0] CH_OUTPUT_VOLT = 4'h4;
   localparam logic [CH_W-1:0] CH_PHASE_TWO = 4'h5;
   localparam logic [CH_W-1:0] CH_REMOTE_TEMP = 4'h6;
   localparam logic [CH_W-1:0] CH_TRACK_REF = 4'h7;
   localparam logic [CH_W-1:0] CH_DIE_TEMP = 4'h8;
   localparam logic [CH_W-1:0] CH_LAST = CH_DIE_TEMP;

   // adc scaling in microvolts
   localparam int FULL_SCALE_UV = 2450000;
   localparam int LSB_UV = 2390;

   // strap address decode
   localparam int BAND_UV = 185000;
   localparam int NUM_BANDS = 12;
   localparam int TOP_LIMIT_UV = 2220000;
   localparam int BAND_W = 4;
   localparam int ADDR_W = 7;
   localparam logic [ADDR_W-1:0] ADDR_MULT = 7'h0c;
   localparam logic [ADDR_W-1:0] ADDR_OVERRIDE = 7'h7f;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;

   // startup delay after the supply is seen good (value is a plain default)
   localparam int STARTUP_US = 100;
   localparam int CLK_MHZ = 50;
   localparam int STARTUP_CYCLES = STARTUP_US * CLK_MHZ;

   // under-voltage trip level on the output voltage channel (plain default)
   localparam logic [ADC_BITS-1:0] UV_THRESH_DEFAULT = 10'h100;

   localparam logic [ADC_BITS-1:0] CODE_ZERO = 10'h000;

   // status word bit positions
   localparam int STAT_READY = 0;
   localparam int STAT_UV = 1;
   localparam int STAT_SCAN_VALID = 2;
   localparam int STAT_ADDR_VALID = 3;
   localparam int STAT_OUT_OFF = 4;
   localparam int STAT_W = 5;

   typedef enum logic [1:0] {
      ST_POR_WAIT,
      ST_STARTUP,
      ST_ISSUE,
      ST_CONVERT
   } mon_state_e;

   // least code that sits at or above a voltage, rounding up
   function automatic logic [ADC_BITS-1:0] uv_to_code(input int uv);
      int c;
      c = (uv + LSB_UV - 1) / LSB_UV; // R2
      if (c > (1 << ADC_BITS) - 1) begin
         c = (1 << ADC_BITS) - 1;
      end
      return c[ADC_BITS-1:0];
   endfunction

endpackage

/* File: strap_decoder.sv */
// strap voltage codes to bus address
`timescale 1ns/1ps
module strap_decoder
   import analog_monitor_pkg::*;
(
   input wire logic [ADC_BITS-1:0] upper_code,
   input wire logic [ADC_BITS-1:0] lower_code,
   output logic [ADDR_W-1:0] bus_addr
);

   // band index counts thresholds crossed; NUM_BANDS means above the top limit
   function automatic logic [BAND_W-1:0] band_index(input logic [ADC_BITS-1:0] code);
      logic [BAND_W-1:0] idx;
      idx = '0;
      for (int n = 1; n <= NUM_BANDS; n++) begin
         if (code >= uv_to_code(n * BAND_UV)) begin // R4 R13
            idx = n[BAND_W-1:0];
         end
      end
      return idx;
   endfunction

   // one spare bit: the top strap bands reach past what seven bits can name
   localparam int SUM_W = ADDR_W + 1;

   logic [BAND_W-1:0] upper_band;
   logic [BAND_W-1:0] lower_band;
   logic [SUM_W-1:0] formula;

   always_comb begin
      upper_band = band_index(upper_code);
      lower_band = band_index(lower_code);
      formula = SUM_W'(upper_band) * SUM_W'(ADDR_MULT) + SUM_W'(lower_band); // R3
      if (upper_band == BAND_W'(NUM_BANDS) || lower_band == BAND_W'(NUM_BANDS)) begin
         bus_addr = ADDR_OVERRIDE; // R5 R13
      end else if (upper_band == '0 && lower_band == '0) begin
         // grounded straps win over the band-zero table entry
         bus_addr = ADDR_OVERRIDE; // R6
      end else if (formula > SUM_W'(ADDR_OVERRIDE)) begin
         // pairs whose sum no seven bit address can hold fall back to the override
         bus_addr = ADDR_OVERRIDE;
      end else begin
         bus_addr = formula[ADDR_W-1:0]; // R3
      end
   end

endmodule

/* File: analog_monitor_monitor.sv */
// port assertions for the analog monitor
`timescale 1ns/1ps
module analog_monitor_monitor
   import analog_monitor_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic bias_supply_ok,
   input wire logic ext_reset,
   input wire logic sys_reset_active,
   input wire logic adc_start,
   input wire logic [CH_W-1:0] adc_channel,
   input wire logic adc_done,
   input wire logic [ADDR_W-1:0] bus_addr,
   input wire logic addr_valid,
   input wire logic output_off,
   input wire logic uv_alarm,
   input wire logic [STAT_W-1:0] supply_status
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   property p_ext; ext_reset |=> sys_reset_active && !addr_valid; endproperty
   a_ext: assert property (p_ext) else $error("ext reset ignored");
   property p_por; !bias_supply_ok |=> sys_reset_active && !adc_start; endproperty
   a_por: assert property (p_por) else $error("ran without supply");
   // a done seen while resetting is stale and proves nothing about the scan
   property p_next; adc_done && !sys_reset_active && !ext_reset |=> adc_channel ==
      ($past(adc_channel) == CH_LAST ? 4'h0 : $past(adc_channel) + 4'h1); endproperty
   a_next: assert property (p_next) else $error("channel order");
   property p_done; adc_done && !sys_reset_active && !ext_reset |->
      ##2 (adc_start || sys_reset_active); endproperty
   a_done: assert property (p_done) else $error("scan stalled");
   property p_hold; addr_valid && $past(addr_valid) |-> $stable(bus_addr); endproperty
   a_hold: assert property (p_hold) else $error("address moved");
   property p_latch; $rose(addr_valid) |-> $past(adc_done) && $past(adc_channel) == CH_LAST;
   endproperty
   a_latch: assert property (p_latch) else $error("address latched early");
   property p_off; (uv_alarm || output_off) && !ext_reset && bias_supply_ok |=> output_off;
   endproperty
   a_off: assert property (p_off) else $error("output not held off");
   property p_stat; supply_status[4:3] == {output_off, addr_valid} &&
      supply_status[1:0] == {uv_alarm, !sys_reset_active}; endproperty
   a_stat: assert property (p_stat) else $error("status word");
endmodule
bind analog_monitor analog_monitor_monitor i_analog_monitor_monitor (.mclk, .rst_b,
   .bias_supply_ok, .ext_reset, .sys_reset_active, .adc_start, .adc_channel, .adc_done,
   .bus_addr, .addr_valid, .output_off, .uv_alarm, .supply_status);

/* File: adc_model.sv */
// behavioural adc answering conversion requests
`timescale 1ns/1ps
module adc_model
   import analog_monitor_pkg::*;
(
   input wire logic mclk,
   input wire logic adc_start,
   input wire logic [CH_W-1:0] adc_channel,
   input wire logic slow,
   input wire logic [ADC_BITS-1:0] codes [NUM_CH],
   output logic adc_done = 1'b0,
   output logic [ADC_BITS-1:0] adc_code = 10'h000
);
   int cnt = -1;
   logic [CH_W-1:0] ch;
   // code toggles outside the done cycle so a stale value is never trusted
   always @(posedge mclk) begin
      adc_done <= 1'b0;
      adc_code <= ~adc_code;
      cnt <= (cnt > 0) ? cnt - 1 : -1;
      if (adc_start) begin
         ch <= adc_channel;
         cnt <= slow ? 6 : 0;
      end else if (cnt == 0) begin
         adc_done <= 1'b1;
         adc_code <= codes[ch];
      end
   end
endmodule

/* File: analog_monitor_test.sv */
// self-checking bench for the analog monitor
`timescale 1ns/1ps
module analog_monitor_test;
   import analog_monitor_pkg::*;
   logic mclk = 1'b0, rst_b = 1'b0, bias_supply_ok = 1'b0, ext_reset = 1'b0, slow = 1'b0;
   logic sys_reset_active, adc_start, adc_done, addr_valid, output_off, uv_alarm;
   logic [CH_W-1:0] adc_channel, rd_channel = 4'h0;
   logic [ADC_BITS-1:0] adc_code, rd_data;
   logic [ADDR_W-1:0] bus_addr;
   logic [STAT_W-1:0] supply_status;
   logic [ADC_BITS-1:0] codes [NUM_CH] = '{10'h000, 10'h000, 10'h011, 10'h022, 10'h200,
      10'h055, 10'h066, 10'h077, 10'h088};
   int failures = 0, checks_done = 0;
   always #10 mclk = ~mclk;
   analog_monitor #(.STARTUP_CNT(8)) i_analog_monitor (.mclk, .rst_b, .bias_supply_ok,
      .ext_reset, .sys_reset_active, .adc_start, .adc_channel, .adc_done, .adc_code, .bus_addr,
      .addr_valid, .output_off, .uv_alarm, .supply_status, .rd_channel, .rd_data);
   adc_model i_adc_model (.mclk, .adc_start, .adc_channel, .slow, .codes, .adc_done, .adc_code);
   task automatic results;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [9:0] e, input logic [9:0] s);
      checks_done++;
      if (s !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   // running out of patience counts as a mismatch and ends the run
   task automatic wait_for(ref logic s, input logic v);
      for (int n = 0; s !== v; n++) begin
         if (n > 3000) begin
            failures++;
            results();
         end
         @(negedge mclk);
      end
   endtask
   task automatic t_startup;
      int n;
      n = 0;
      bias_supply_ok = 1'b1;
      while (sys_reset_active === 1'b1 && n < 50) begin
         @(negedge mclk);
         n++;
      end
      chk("startup", 10'h009, 10'(n));
      chk("ready", 10'h001, 10'(supply_status[STAT_READY]));
      if (n >= 50) begin
         results();
      end
   endtask
   task automatic t_read;
      for (int c = 0; c < 10; c++) begin
         rd_channel = 4'(c);
         @(negedge mclk);
         chk("rd_data", (c < NUM_CH) ? codes[c] : CODE_ZERO, rd_data);
      end
   endtask
   task automatic t_uv;
      codes[CH_OUTPUT_VOLT] = 10'h0ff;
      wait_for(uv_alarm, 1'b1);
      @(negedge mclk);
      chk("status", 10'h01f, 10'(supply_status));
      codes[CH_OUTPUT_VOLT] = 10'h100;
      wait_for(uv_alarm, 1'b0);
      chk("status", 10'h01d, 10'(supply_status));
   endtask
   task automatic t_addr(input logic [9:0] up, input logic [9:0] lo, input logic [6:0] e);
      codes[CH_STRAP_UPPER] = up;
      codes[CH_STRAP_LOWER] = lo;
      ext_reset = 1'b1;
      @(negedge mclk);
      ext_reset = 1'b0;
      chk("addr_valid", 10'h000, 10'(addr_valid));
      chk("bus_addr", 10'(ADDR_RESET), 10'(bus_addr));
      wait_for(addr_valid, 1'b1);
      chk("bus_addr", 10'(e), 10'(bus_addr));
   endtask
   task automatic t_supply_loss;
      bias_supply_ok = 1'b0;
      @(negedge mclk);
      chk("status", 10'h000, 10'(supply_status));
      repeat (4) @(negedge mclk);
      chk("adc_start", 10'h000, 10'(adc_start));
      chk("sys_reset_active", 10'h001, 10'(sys_reset_active));
      bias_supply_ok = 1'b1;
      wait_for(addr_valid, 1'b1);
      chk("bus_addr", 10'h07f, 10'(bus_addr));
   endtask
   task automatic t_hold;
      codes[CH_STRAP_UPPER] = 10'h000;
      repeat (100) @(negedge mclk);
      chk("bus_addr", 10'h01a, 10'(bus_addr));
   endtask
   initial begin
      repeat (12) @(negedge mclk);
      rst_b = 1'b1;
      t_startup();
      wait_for(addr_valid, 1'b1);
      t_read();
      t_uv();
      t_supply_loss();
      t_addr(10'h000, 10'h000, 7'h7f);
      t_addr(10'h04d, 10'h04e, 7'h01);
      slow = 1'b1;
      t_addr(10'h04e, 10'h000, 7'h0c);
      t_addr(10'h3a1, 10'h000, 7'h7f);
      slow = 1'b0;
      t_addr(10'h000, 10'h3a1, 7'h7f);
      t_addr(10'h2b9, 10'h3a0, 7'h77);
      t_addr(10'h3a0, 10'h3a0, 7'h7f);
      t_addr(10'h09b, 10'h0e8, 7'h1a);
      t_hold();
      results();
   end
endmodule
